// >>> include/lsw_consts.svh
// constants of the load string and word unit
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH
`define LSW_REG_IDX_W 5
`define LSW_WORD_BYTES 4
`define LSW_WORD_W 32
`define LSW_ADDR_W 64
`define LSW_CNT_W 7
`define LSW_IMM_CNT_W 5
`define LSW_IMM_ZERO_BYTES 7'h20
`define LSW_XLEN_DEF 64
`endif

// >>> include/lsw_pkg.sv
// types shared by the load string and word unit
`include "lsw_consts.svh"
package lsw_pkg;
   typedef enum logic [1:0] {
      LSW_OP_STR_IMM,
      LSW_OP_STR_IDX,
      LSW_OP_WORD_SEXT,
      LSW_OP_WORD_RSV
   } lsw_op_t;

   typedef enum logic {
      LSW_ST_IDLE,
      LSW_ST_ACCESS
   } lsw_state_t;

   typedef struct packed {
      logic valid;
      lsw_op_t op;
      logic legacy;
      logic [`LSW_REG_IDX_W-1:0] target_reg_field;
      logic [`LSW_REG_IDX_W-1:0] base_reg_field;
      logic [`LSW_REG_IDX_W-1:0] index_reg_field;
      logic [`LSW_IMM_CNT_W-1:0] immediate_byte_count;
      logic [`LSW_CNT_W-1:0] exc_reg_count;
   } lsw_issue_t;

   typedef struct packed {
      logic we;
      logic [`LSW_REG_IDX_W-1:0] idx;
   } lsw_gpr_wr_t;
endpackage

// >>> design/lsw_ea_gen.sv
// effective address generation for the load string and word unit
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_ea_gen
   import lsw_pkg::*;
(
   input wire lsw_op_t op,
   input wire logic [`LSW_REG_IDX_W-1:0] base_reg_field,
   input wire logic [`LSW_ADDR_W-1:0] base_val,
   input wire logic [`LSW_ADDR_W-1:0] index_val,
   output logic [`LSW_ADDR_W-1:0] effective_address
);
   logic base_zero;
   assign base_zero = (base_reg_field == '0);

   always_comb begin
      if (op == LSW_OP_STR_IMM) begin
         // base alone, or zero when the base field names register 0 (see [R1])
         effective_address = base_zero ? '0 : base_val;
      end else begin
         // indexed forms: index alone or base plus index (see [R10]) (see [R16])
         effective_address = base_zero ? index_val : base_val + index_val;
      end
   end
endmodule

// >>> design/lsw_load_unit.sv
// load string, sign-extending word and load-and-reserve execution unit
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Immediate string load address is base register, or zero for field 0.
// [R2] Immediate count taken from field; encoded zero means 32 bytes.
// [R3] Bytes fill consecutive registers leftmost first, wrapping 31 to 0.
// [R4] Legacy forms clear unfilled right bytes of the final register.
// [R5] Software avoids base in range and target=base=0 on immediate form.
// [R6] Legacy immediate form skips writing a nonzero base inside the range.
// [R7] Legacy indexed form skips writing nonzero base and index in range; the unit skips the index only when the base field is nonzero.
// [R8] String loads leave exception register and condition field unchanged.
// [R9] Storage fault aborts; instruction reissues from its first byte.
// [R10] Indexed string address is base plus index, or index for field 0.
// [R11] Indexed string count comes from exception register bits 25-31.
// [R12] Indexed count of zero writes no register.
// [R13] Software keeps base and index outside range on newer indexed form.
// [R14] Sign-extending load fills low word and replicates sign upward.
// [R15] Sign-extending load is illegal on a 32-bit implementation.
// [R16] Reserve load address is index, or base plus index.
// [R17] Reserve load writes target and sets a reservation on the address.
// [R18] Conditional store succeeds only if reserved word stayed unmodified.
// [R19] Software gives reserve load a word-aligned address.
// [R20] Reserve load leaves the exception register unchanged.
// [R21] Accesses ascend; destination advances every fourth byte; done ends all.
`include "lsw_consts.svh"
module lsw_load_unit
   import lsw_pkg::*;
#(
   parameter int XLEN = `LSW_XLEN_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire lsw_issue_t issue,
   input wire logic [`LSW_ADDR_W-1:0] base_val,
   input wire logic [`LSW_ADDR_W-1:0] index_val,
   output logic issue_ready_ff,
   output logic mem_req_ff,
   output logic [`LSW_ADDR_W-1:0] mem_addr_ff,
   input wire logic mem_ack,
   input wire logic mem_fault,
   input wire logic [`LSW_WORD_W-1:0] mem_rdata,
   output lsw_gpr_wr_t gpr_wr_ff,
   output logic [XLEN-1:0] gpr_wdata_ff,
   output logic done_ff,
   output logic restart_ff,
   output logic illegal_ff,
   input wire logic snoop_we,
   input wire logic [`LSW_ADDR_W-1:0] snoop_addr,
   input wire logic stcx_req,
   input wire logic [`LSW_ADDR_W-1:0] stcx_addr,
   output logic stcx_resp_ff,
   output logic stcx_ok_ff,
   output logic resv_valid_ff
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   generate
      if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
         $error("lsw_load_unit: XLEN must be 32 or 64");
      end
   endgenerate

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // keep the leftmost n bytes of a word, zero the rest
   function automatic logic [`LSW_WORD_W-1:0] keep_left(
      input logic [`LSW_WORD_W-1:0] w,
      input logic [`LSW_CNT_W-1:0] n
   );
      logic [`LSW_WORD_W-1:0] m;
      m = '1;
      case (n)
         7'h01: m = 32'hff00_0000;
         7'h02: m = 32'hffff_0000;
         7'h03: m = 32'hffff_ff00;
         default: m = '1;
      endcase
      return w & m;
   endfunction

   function automatic logic same_word(
      input logic [`LSW_ADDR_W-1:0] a,
      input logic [`LSW_ADDR_W-1:0] b
   );
      return a[`LSW_ADDR_W-1:2] == b[`LSW_ADDR_W-1:2];
   endfunction

   // ----------------------------------------------------------------
   // issue decode
   // ----------------------------------------------------------------
   lsw_state_t state_ff;
   lsw_op_t op_ff;
   logic legacy_ff;
   logic [`LSW_REG_IDX_W-1:0] dst_ff;
   logic [`LSW_REG_IDX_W-1:0] base_fld_ff;
   logic [`LSW_REG_IDX_W-1:0] idx_fld_ff;
   logic [`LSW_CNT_W-1:0] left_ff;
   logic [`LSW_ADDR_W-1:0] eff_addr;
   logic accept;
   logic [`LSW_CNT_W-1:0] issue_cnt;
   logic zero_cnt;
   logic no_sext;
   logic is_str;
   logic last;
   logic discard;
   logic take;
   logic fault;

   lsw_ea_gen u_ea (
      .op(issue.op),
      .base_reg_field(issue.base_reg_field),
      .base_val(base_val),
      .index_val(index_val),
      .effective_address(eff_addr)
   );

   assign accept = issue.valid && issue_ready_ff;

   always_comb begin
      if (issue.op == LSW_OP_STR_IMM) begin
         // encoded zero stands for a full 32-byte transfer (see [R2])
         issue_cnt = (issue.immediate_byte_count == '0) ? `LSW_IMM_ZERO_BYTES
                   : {2'h0, issue.immediate_byte_count};
      end else begin
         issue_cnt = issue.exc_reg_count; // see [R11]
      end
   end

   assign zero_cnt = (issue.op == LSW_OP_STR_IDX) && (issue_cnt == '0);
   assign no_sext = (issue.op == LSW_OP_WORD_SEXT) && (XLEN == 32);
   assign is_str = (op_ff == LSW_OP_STR_IMM) || (op_ff == LSW_OP_STR_IDX);
   assign last = !is_str || (left_ff <= 7'(`LSW_WORD_BYTES));
   assign take = (state_ff == LSW_ST_ACCESS) && mem_ack;
   assign fault = take && mem_fault;

   // legacy forms protect a nonzero base inside the range, and the index only when the base field is nonzero
   always_comb begin
      discard = 1'b0;
      if (is_str && legacy_ff && base_fld_ff != '0) begin
         if (dst_ff == base_fld_ff) begin
            discard = 1'b1; // see [R6]
         end
         if (op_ff == LSW_OP_STR_IDX && dst_ff == idx_fld_ff) begin
            discard = 1'b1; // see [R7]
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= LSW_ST_IDLE;
         issue_ready_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            LSW_ST_IDLE: begin
               issue_ready_ff <= 1'b1;
               if (accept && !zero_cnt && !no_sext) begin
                  state_ff <= LSW_ST_ACCESS;
                  issue_ready_ff <= 1'b0;
               end
            end
            LSW_ST_ACCESS: begin
               // a fault drops all progress: the core reissues from byte 0
               if (fault || (take && last)) begin // see [R9]
                  state_ff <= LSW_ST_IDLE;
                  issue_ready_ff <= 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         op_ff <= LSW_OP_STR_IMM;
         legacy_ff <= 1'b0;
         base_fld_ff <= '0;
         idx_fld_ff <= '0;
      end else if (accept) begin
         op_ff <= issue.op;
         legacy_ff <= issue.legacy;
         base_fld_ff <= issue.base_reg_field;
         idx_fld_ff <= issue.index_reg_field;
      end
   end

   // destination and address walk upward together while the byte count walks down
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dst_ff <= '0;
         left_ff <= '0;
         mem_addr_ff <= '0;
      end else if (accept) begin
         dst_ff <= issue.target_reg_field;
         left_ff <= issue_cnt;
         mem_addr_ff <= eff_addr;
      end else if (take && !fault && !last) begin
         dst_ff <= dst_ff + 5'h01; // wraps from 31 to 0 (see [R3]) (see [R21])
         left_ff <= left_ff - 7'(`LSW_WORD_BYTES);
         mem_addr_ff <= mem_addr_ff + 64'(`LSW_WORD_BYTES);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mem_req_ff <= 1'b0;
      end else if (accept && !zero_cnt && !no_sext) begin
         mem_req_ff <= 1'b1;
      end else if (fault || (take && last)) begin
         mem_req_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register write port
   // ----------------------------------------------------------------
   // no exception register or condition field port exists here, so
   // neither is ever touched (see [R8]) (see [R20])
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         gpr_wr_ff <= '0;
         gpr_wdata_ff <= '0;
      end else begin
         gpr_wr_ff.we <= take && !fault && !discard;
         gpr_wr_ff.idx <= dst_ff;
         if (take) begin
            if (op_ff == LSW_OP_WORD_SEXT) begin
               gpr_wdata_ff <= XLEN'(signed'(mem_rdata)); // see [R14]
            end else if (is_str) begin
               // partial last register: right bytes cleared (see [R4])
               gpr_wdata_ff <= XLEN'(keep_left(mem_rdata, left_ff)); // see [R3]
            end else begin
               gpr_wdata_ff <= XLEN'(mem_rdata); // see [R17]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // completion pulses
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         done_ff <= 1'b0;
         restart_ff <= 1'b0;
         illegal_ff <= 1'b0;
      end else begin
         // zero indexed count finishes at once with no write (see [R12])
         done_ff <= (accept && zero_cnt) || (take && !fault && last);
         restart_ff <= fault; // see [R9]
         illegal_ff <= accept && no_sext; // see [R15]
      end
   end

   // ----------------------------------------------------------------
   // reservation
   // ----------------------------------------------------------------
   logic [`LSW_ADDR_W-1:0] resv_addr_ff;
   logic rsv_set;
   logic resv_hit;

   assign rsv_set = take && !fault && op_ff == LSW_OP_WORD_RSV;
   assign resv_hit = snoop_we && same_word(snoop_addr, resv_addr_ff);

   // a new reservation wins over a snoop or store in the same cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         resv_valid_ff <= 1'b0;
         resv_addr_ff <= '0;
      end else if (rsv_set) begin
         resv_valid_ff <= 1'b1; // see [R17]
         resv_addr_ff <= mem_addr_ff;
      end else if (resv_hit || stcx_req) begin
         resv_valid_ff <= 1'b0; // see [R18]
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stcx_resp_ff <= 1'b0;
         stcx_ok_ff <= 1'b0;
      end else begin
         stcx_resp_ff <= stcx_req;
         // a write landing in the same cycle also spoils the store (see [R18])
         stcx_ok_ff <= stcx_req && resv_valid_ff && !resv_hit
                       && same_word(stcx_addr, resv_addr_ff);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_acc_imm;
      accept && issue.op == LSW_OP_STR_IMM;
   endsequence

   sequence s_fault;
      take && mem_fault;
   endsequence

   sequence s_abort;
      restart_ff && !gpr_wr_ff.we && !done_ff ##1 issue_ready_ff;
   endsequence

   AST_IMM_EA: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R1]
      s_acc_imm |=> mem_addr_ff == ($past(issue.base_reg_field) == '0 ? '0 : $past(base_val)))
      else $error("immediate string address wrong");

   AST_IMM_ZERO_32: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R2]
      accept && issue.op == LSW_OP_STR_IMM && issue.immediate_byte_count == '0
      |=> left_ff == `LSW_IMM_ZERO_BYTES)
      else $error("zero immediate count not 32 bytes");

   AST_IDX_EA: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R10]
      accept && issue.op != LSW_OP_STR_IMM && issue.base_reg_field != '0
      |=> mem_addr_ff == $past(base_val) + $past(index_val))
      else $error("indexed address not base plus index");

   AST_RSV_EA: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R16]
      accept && issue.op == LSW_OP_WORD_RSV && issue.base_reg_field == '0
      |=> mem_addr_ff == $past(index_val))
      else $error("reserve load address not index alone");

   AST_ZERO_CNT: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R12]
      accept && zero_cnt |=> done_ff && !gpr_wr_ff.we ##1 !mem_req_ff && !gpr_wr_ff.we)
      else $error("zero indexed count touched a register");

   AST_ADVANCE: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R21]
      take && !mem_fault && !last
      |=> dst_ff == $past(dst_ff) + 5'h01 && mem_addr_ff == $past(mem_addr_ff) + 64'h4)
      else $error("string walk did not advance");

   AST_LEGACY_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R4]
      take && !mem_fault && is_str && left_ff == 7'h01
      |=> gpr_wdata_ff[23:0] == '0 && done_ff)
      else $error("partial register not cleared");

   AST_BASE_KEPT: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R6]
      take && legacy_ff && is_str && base_fld_ff != '0 && dst_ff == base_fld_ff
      |=> !gpr_wr_ff.we)
      else $error("legacy base register overwritten");

   AST_SEXT: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R14]
      take && !mem_fault && op_ff == LSW_OP_WORD_SEXT
      |=> gpr_wr_ff.we && gpr_wdata_ff == XLEN'(signed'($past(mem_rdata))))
      else $error("fullword load not sign extended");

   AST_ILLEGAL: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R15]
      accept && no_sext |=> illegal_ff && !mem_req_ff)
      else $error("sign-extending load not refused");

   AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R9]
      s_fault |=> s_abort)
      else $error("fault did not abort the instruction");

   AST_RESERVE: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R17]
      rsv_set |=> resv_valid_ff && resv_addr_ff == $past(mem_addr_ff))
      else $error("reservation not established");

   AST_STCX_LOST: assert property (@(posedge clk_sys) disable iff (!rstn) // see [R18]
      stcx_req && snoop_we && same_word(snoop_addr, stcx_addr) |=> stcx_resp_ff && !stcx_ok_ff)
      else $error("conditional store passed over a write");
endmodule

// >>> testbench/lsw_mem_model.sv
// storage model that answers the unit's word reads
`timescale 1ns/1ps
module lsw_mem_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic mem_req,
   input wire logic [63:0] mem_addr,
   input wire logic [31:0] delay,
   input wire logic fault_en,
   input wire logic [63:0] fault_addr,
   output logic mem_ack,
   output logic mem_fault,
   output logic [31:0] mem_rdata
);
   int cnt;
   function automatic logic [31:0] word_at(input logic [63:0] a);
      return {a[7:0] + 8'h41, a[7:0] + 8'h42, a[7:0] + 8'h43, a[7:0] + 8'h44};
   endfunction
   // ---
   // answer after delay idle cycles
   // ---
   // rdata toggles outside the ack so stale data never looks valid
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mem_ack <= 1'b0;
         mem_fault <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 0;
      end else if (mem_ack || !mem_req || cnt < delay) begin
         mem_ack <= 1'b0;
         mem_fault <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
      end else begin
         mem_ack <= 1'b1;
         mem_fault <= fault_en && (mem_addr == fault_addr);
         mem_rdata <= word_at(mem_addr);
         cnt <= 0;
      end
   end
endmodule

// >>> testbench/test_load_string_word_unit.sv
// self-checking bench for the load string and word unit
`timescale 1ns/1ps
module test_load_string_word_unit import lsw_pkg::*;;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   lsw_issue_t issue = '0;
   lsw_issue_t issue32 = '0;
   logic [63:0] base_val = 64'h0;
   logic [63:0] index_val = 64'h0;
   logic snoop_we = 1'b0;
   logic [63:0] snoop_addr = 64'h0;
   logic stcx_req = 1'b0;
   logic [63:0] stcx_addr = 64'h0;
   int delay = 0;
   logic fault_en = 1'b0;
   logic [63:0] fault_addr = 64'h0;
   logic issue_ready_ff, mem_req_ff, mem_ack, mem_fault, done_ff, restart_ff, illegal_ff;
   logic stcx_resp_ff, stcx_ok_ff, resv_valid_ff, ill32;
   logic [63:0] mem_addr_ff, gpr_wdata_ff;
   logic [31:0] mem_rdata;
   lsw_gpr_wr_t gpr_wr_ff;
   logic [4:0] wq_idx[$];
   logic [63:0] wq_dat[$];
   logic [63:0] aq[$];
   int err_count = 0;
   int checks = 0;
   int ended;

   always #50 clk_sys = ~clk_sys;

   lsw_load_unit #(.XLEN(64)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .issue(issue),
      .base_val(base_val), .index_val(index_val), .issue_ready_ff(issue_ready_ff),
      .mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff), .mem_ack(mem_ack),
      .mem_fault(mem_fault), .mem_rdata(mem_rdata), .gpr_wr_ff(gpr_wr_ff),
      .gpr_wdata_ff(gpr_wdata_ff), .done_ff(done_ff), .restart_ff(restart_ff),
      .illegal_ff(illegal_ff), .snoop_we(snoop_we), .snoop_addr(snoop_addr),
      .stcx_req(stcx_req), .stcx_addr(stcx_addr), .stcx_resp_ff(stcx_resp_ff),
      .stcx_ok_ff(stcx_ok_ff), .resv_valid_ff(resv_valid_ff));
   // a 32-bit core only to see the sign-extending load refused; it never leaves
   // idle, so sharing the storage answers with the 64-bit unit cannot disturb it
   lsw_load_unit #(.XLEN(32)) dut_u32 (.clk_sys(clk_sys), .rstn(rstn), .issue(issue32),
      .base_val(base_val), .index_val(index_val), .issue_ready_ff(), .mem_req_ff(),
      .mem_addr_ff(), .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata),
      .gpr_wr_ff(),
      .gpr_wdata_ff(), .done_ff(), .restart_ff(), .illegal_ff(ill32), .snoop_we(snoop_we),
      .snoop_addr(snoop_addr), .stcx_req(stcx_req), .stcx_addr(stcx_addr),
      .stcx_resp_ff(), .stcx_ok_ff(), .resv_valid_ff());
   lsw_mem_model mem_u (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req_ff),
      .mem_addr(mem_addr_ff), .delay(delay), .fault_en(fault_en), .fault_addr(fault_addr),
      .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata));

   always @(posedge clk_sys) begin
      if (gpr_wr_ff.we === 1'b1) begin
         wq_idx.push_back(gpr_wr_ff.idx);
         wq_dat.push_back(gpr_wdata_ff);
      end
      if (mem_req_ff === 1'b1 && mem_ack === 1'b1) begin
         aq.push_back(mem_addr_ff);
      end
   end

   // ---
   // shared tasks
   // ---
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // issue one instruction and wait for its end; ended 1 done, 2 restart, 3 illegal
   task automatic go(input lsw_op_t op, input logic leg, input logic [4:0] dst, bse, ndx, imm,
                     input logic [6:0] xc);
      int n;
      wq_idx.delete();
      wq_dat.delete();
      aq.delete();
      for (n = 0; n < 100 && issue_ready_ff !== 1'b1; n++) begin
         @(posedge clk_sys);
         #10;
      end
      issue = '{1'b1, op, leg, dst, bse, ndx, imm, xc};
      @(posedge clk_sys);
      #10 issue.valid = 1'b0;
      ended = 0;
      for (n = 0; n < 300 && ended == 0; n++) begin
         if (done_ff === 1'b1) ended = 1;
         else if (restart_ff === 1'b1) ended = 2;
         else if (illegal_ff === 1'b1) ended = 3;
         @(posedge clk_sys);
         #10;
      end
   endtask

   // s1, s2 name registers that must stay unwritten (99 for none)
   task automatic exp_str(input logic [4:0] dst, input int n, input logic [63:0] addr0,
                          input int s1, input int s2);
      int k;
      logic [4:0] r;
      logic [31:0] w;
      k = 0;
      chk(64'(ended), 64'd1);
      chk(64'(issue_ready_ff), 64'd1);
      chk(64'(aq.size()), 64'((n + 3) / 4));
      for (int i = 0; i < (n + 3) / 4; i++) begin
         r = dst + 5'(i);
         w = mem_u.word_at(addr0 + 64'(4 * i));
         for (int j = 0; j < 4; j++) begin
            if (4 * i + j >= n) w[31 - 8 * j -: 8] = 8'h0;
         end
         chk(aq[i], addr0 + 64'(4 * i));
         if (int'(r) != s1 && int'(r) != s2) begin
            chk(64'(wq_idx[k]), 64'(r));
            chk(wq_dat[k], {32'h0, w});
            k++;
         end
      end
      chk(64'(wq_idx.size()), 64'(k));
   endtask

   // snp also reports a foreign write to the same word in the query cycle
   task automatic stcx(input logic [63:0] a, input logic ok, input logic snp);
      stcx_req = 1'b1;
      stcx_addr = a;
      if (snp) begin
         snoop_we = 1'b1;
         snoop_addr = a;
      end
      @(posedge clk_sys);
      #10 stcx_req = 1'b0;
      if (snp) snoop_we = 1'b0;
      chk(64'(stcx_resp_ff), 64'd1);
      chk(64'(stcx_ok_ff), 64'(ok));
   endtask

   // ---
   // scenarios
   // ---
   task automatic t_imm();
      base_val = 64'h1000;
      go(LSW_OP_STR_IMM, 1'b0, 5'd6, 5'd9, 5'd0, 5'd6, 7'd0);
      exp_str(5'd6, 6, 64'h1000, 99, 99);
      delay = 2;
      base_val = 64'hdead_0000;
      go(LSW_OP_STR_IMM, 1'b1, 5'd30, 5'd0, 5'd0, 5'd0, 7'd0);
      exp_str(5'd30, 32, 64'h0, 99, 99);
      delay = 0;
   endtask

   task automatic t_leg();
      base_val = 64'h2000;
      go(LSW_OP_STR_IMM, 1'b1, 5'd7, 5'd8, 5'd0, 5'd9, 7'd0);
      exp_str(5'd7, 9, 64'h2000, 8, 99);
      base_val = 64'h300;
      index_val = 64'h20;
      go(LSW_OP_STR_IDX, 1'b1, 5'd9, 5'd9, 5'd10, 5'd0, 7'd12);
      exp_str(5'd9, 12, 64'h320, 9, 10);
      index_val = 64'h44;
      go(LSW_OP_STR_IDX, 1'b0, 5'd3, 5'd0, 5'd8, 5'd7, 7'd5);
      exp_str(5'd3, 5, 64'h44, 99, 99);
      go(LSW_OP_STR_IDX, 1'b0, 5'd3, 5'd1, 5'd4, 5'd7, 7'd0);
      chk(64'(ended), 64'd1);
      chk(64'(wq_idx.size() + aq.size()), 64'd0);
   endtask

   task automatic t_fault();
      base_val = 64'h1000;
      fault_addr = 64'h1004;
      fault_en = 1'b1;
      go(LSW_OP_STR_IMM, 1'b0, 5'd12, 5'd1, 5'd0, 5'd8, 7'd0);
      chk(64'(ended), 64'd2);
      chk(64'(wq_idx.size()), 64'd1);
      fault_en = 1'b0;
      go(LSW_OP_STR_IMM, 1'b0, 5'd12, 5'd1, 5'd0, 5'd8, 7'd0);
      exp_str(5'd12, 8, 64'h1000, 99, 99);
   endtask

   task automatic t_word();
      logic [63:0] al[2] = '{64'h240, 64'h10};
      logic [31:0] w;
      for (int i = 0; i < 2; i++) begin
         index_val = al[i];
         w = mem_u.word_at(al[i]);
         go(LSW_OP_WORD_SEXT, 1'b0, 5'd5, 5'd0, 5'd6, 5'd0, 7'd0);
         chk(64'(ended), 64'd1);
         chk(aq[0], al[i]);
         chk(64'(wq_idx[0]), 64'd5);
         chk(wq_dat[0], {{32{w[31]}}, w});
      end
   endtask

   task automatic t_rsv();
      base_val = 64'h5000;
      index_val = 64'h8;
      go(LSW_OP_WORD_RSV, 1'b0, 5'd4, 5'd2, 5'd3, 5'd0, 7'd0);
      chk(aq[0], 64'h5008);
      chk(wq_dat[0], {32'h0, mem_u.word_at(64'h5008)});
      chk(64'(resv_valid_ff), 64'd1);
      stcx(64'h5008, 1'b1, 1'b0);
      chk(64'(resv_valid_ff), 64'd0);
      go(LSW_OP_WORD_RSV, 1'b0, 5'd4, 5'd2, 5'd3, 5'd0, 7'd0);
      snoop_we = 1'b1;
      snoop_addr = 64'h500a;
      @(posedge clk_sys);
      #10 snoop_we = 1'b0;
      stcx(64'h5008, 1'b0, 1'b0);
      // base field zero: index alone, and a write in the very query cycle
      base_val = 64'h0;
      index_val = 64'h5008;
      go(LSW_OP_WORD_RSV, 1'b0, 5'd4, 5'd0, 5'd3, 5'd0, 7'd0);
      chk(aq[0], 64'h5008);
      stcx(64'h5008, 1'b0, 1'b1);
      chk(64'(resv_valid_ff), 64'd0);
   endtask

   task automatic t_ill();
      logic hit;
      hit = 1'b0;
      issue32 = '{1'b1, LSW_OP_WORD_SEXT, 1'b0, 5'd5, 5'd0, 5'd6, 5'd0, 7'd0};
      @(posedge clk_sys);
      #10 issue32.valid = 1'b0;
      repeat (5) begin
         if (ill32 === 1'b1) hit = 1'b1;
         @(posedge clk_sys);
         #10;
      end
      chk(64'(hit), 64'd1);
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      #10 rstn = 1'b1;
      t_imm();
      t_leg();
      t_fault();
      t_word();
      t_rsv();
      t_ill();
      results();
   end

   // the whole sequence needs little more than a hundred cycles; allow far more
   initial begin
      #4_000_000;
      err_count++;
      results();
   end
endmodule
